// ---- pkg/rsc_pkg.sv ----
// Constants, register map and carrier types of the reset-source and watchdog block.
package rsc_pkg;

   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int unsigned CLK_PERIOD_NS   = 10;
   localparam int unsigned POR_DELAY_MS    = 100;
   localparam int unsigned POR_DELAY_CYC   = POR_DELAY_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned MCD_TIMEOUT_US  = 220;
   localparam int unsigned MCD_TIMEOUT_CYC = MCD_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
   localparam int unsigned PIN_EXIT_CYC    = 12;
   localparam int unsigned INT_HOLD_CYC    = 12;
   localparam int unsigned HOLD_W          = 24;
   localparam int unsigned MCD_W           = 20;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] CAUSE_ADDR = 8'hef;
   localparam logic [7:0] WDOG_ADDR  = 8'hff;

   // Watchdog control commands.
   localparam logic [7:0] CMD_ENABLE = 8'ha5;
   localparam logic [7:0] CMD_DIS1   = 8'hde;
   localparam logic [7:0] CMD_DIS2   = 8'had;
   localparam logic [7:0] CMD_LOCK   = 8'hff;

   // Watchdog control fields.
   localparam int unsigned WD_CMDBIT  = 7;
   localparam int unsigned WD_RUNBIT  = 4;
   localparam logic [2:0]  WD_IV_RST  = 3'h7;
   localparam logic [2:0]  DIS_WIN    = 3'h4;
   localparam int unsigned WDOG_EXP   = 3;
   localparam int unsigned WDOG_CNT_W = 21;

   // Reset cause bit positions.
   localparam int unsigned RC_CNV = 6;
   localparam int unsigned RC_CMP = 5;
   localparam int unsigned RC_SW  = 4;
   localparam int unsigned RC_MCD = 2;
   localparam int unsigned RC_POR = 1;
   localparam int unsigned RC_PIN = 0;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } rsc_reg_req_t;

   typedef struct packed {
      logic cnv;
      logic cmp;
      logic sw;
      logic wdog;
      logic mcd;
      logic por;
      logic pin;
   } rsc_cause_t;

   localparam rsc_cause_t CAUSE_NONE = 7'h00;
   localparam rsc_cause_t CAUSE_POR  = 7'h02;

   typedef enum logic [1:0] {
      ST_RUN     = 2'h0,
      ST_PIN_LOW = 2'h1,
      ST_HOLD    = 2'h3
   } rsc_state_t;

endpackage

// ---- src/rsc_wdog_timer.sv ----
// Watchdog counter with a programmable power-of-four timeout.
`timescale 1ns/1ps
`default_nettype none

module rsc_wdog_timer
   import rsc_pkg::*;
#(
   parameter int unsigned CNT_W = WDOG_CNT_W
) (
   input  wire logic       clk_sys,
   input  wire logic       srst,
   input  wire logic       restart,
   input  wire logic       run,
   input  wire logic [2:0] interval,
   output logic            expired
);

   // ----------------------------------------
   // Elaboration check
   // ----------------------------------------
   generate
      if (CNT_W < 2 * (WDOG_EXP + 7) + 1) begin : g_bad_width
         $error("rsc_wdog_timer: counter too narrow for the longest interval");
      end
   endgenerate

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] last_cnt;
   logic [4:0]       shift;

   // The last count is four to the power of (3 + interval) minus one.
   always_comb begin
      shift    = 5'(2 * (WDOG_EXP + 32'(interval)));
      last_cnt = ~({CNT_W{1'b1}} << shift); // R7
   end

   // Count system clocks while running; a restart reloads the start value.
   always_ff @(posedge clk_sys) begin
      if (srst || restart) begin
         count   <= '0;
         expired <= 1'b0;
      end else if (run && count == last_cnt) begin
         count   <= '0;
         expired <= 1'b1; // R7
      end else begin
         count   <= run ? count + 1'b1 : count;
         expired <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// ---- src/rsc_reset_ctrl.sv ----
// Reset-source control, reset sequencer and watchdog of the microcontroller.
//
// Summary of operation
// (R1) Writing 0xa5 to watchdog control starts a stopped watchdog and reloads it.
// (R2) 0xde then 0xad within four clocks stops the watchdog; else ignored.
// (R3) Writing 0xff sets the disable lock without enabling or reloading.
// (R4) A set lock blocks every disable sequence until the next system reset.
// (R5) Watchdog control bit 4 reads 1 while counting, 0 while stopped.
// (R6) Low three bits hold the interval, written with bit 7 clear.
// (R7) Timeout is four to the power (3 + interval) clocks; overflow resets.
// (R8) Every system reset sets the interval field to 111 binary.
// (R9) Every system reset leaves the watchdog enabled, counting from zero.
// (R10) Bit 6 enables the convert-start input as active-low source; reads its flag.
// (R11) Bit 5 enables comparator zero low as reset source; reads its flag.
// (R12) Writing 1 to bit 4 forces an internal reset without the pin.
// (R13) Bit 3 reads 1 only after a watchdog timeout reset; read-only.
// (R14) Bit 2 enables the missing-clock detector; reads its flag.
// (R15) Missing-clock reset starts about 220 us after the last clock tick.
// (R16) With the strap high, bit 1 selects the supply monitor as source.
// (R17) Bit 1 reads 1 after power-on or supply reset, 0 after others.
// (R18) Software treats other flags and memory as unknown when bit 1 reads 1.
// (R19) Writing 1 to bit 0 forces a power-on reset and drives the pin low.
// (R20) Bit 0 reads 1 only after a reset from the external reset pin.
// (R21) After power-on the reset pin stays low for 100 ms before release.
// (R22) After other resets only the flag of the actual cause reads 1.
// (R23) Any write other than 0xad inside the window abandons the disable; here only watchdog control writes do, and 0xde reopens the window.
`timescale 1ns/1ps
`default_nettype none

module rsc_reset_ctrl
   import rsc_pkg::*;
#(
   parameter int unsigned POR_CYC = POR_DELAY_CYC,
   parameter int unsigned MCD_CYC = MCD_TIMEOUT_CYC
) (
   input  wire logic         clk_sys,
   input  wire logic         srst,
   input  wire rsc_reg_req_t reg_req,
   output logic [7:0]        reg_rdata,
   input  wire logic         rst_pin_in,
   output logic              rst_pin_out,
   output logic              rst_pin_oe_n,
   input  wire logic         convert_start_input,
   input  wire logic         analog_comparator_zero,
   input  wire logic         supply_monitor_strap_pin,
   input  wire logic         supply_above_threshold,
   input  wire logic         monitored_clock_tick,
   output logic              sys_reset,
   output logic              watchdog_running
);

   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   generate
      if (POR_CYC < 1 || POR_CYC >= (1 << HOLD_W)) begin : g_bad_por
         $error("rsc_reset_ctrl: POR_CYC out of range");
      end
      if (MCD_CYC < 1 || MCD_CYC >= (1 << MCD_W)) begin : g_bad_mcd
         $error("rsc_reset_ctrl: MCD_CYC out of range");
      end
   endgenerate

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   rsc_state_t        state;
   logic [HOLD_W-1:0] hold_cnt;
   logic              hold_por;
   rsc_cause_t        cause_flags;
   logic              in_run;
   logic              wr_wdog;
   logic              wr_cause;
   logic [2:0]        interval;
   logic              dis_lock;
   logic [2:0]        dis_arm;
   logic              wd_restart;
   logic              wd_expired;
   logic              cnv_en;
   logic              cmp_en;
   logic              mcd_en;
   logic              mon_sel;
   logic [MCD_W-1:0]  mcd_cnt;
   logic              mcd_timeout;
   logic              next_trig;
   logic              next_por;
   logic              next_pin;
   rsc_cause_t        next_flags;

   localparam logic [HOLD_W-1:0] POR_LAST = HOLD_W'(POR_CYC - 1);
   localparam logic [HOLD_W-1:0] PIN_LAST = HOLD_W'(PIN_EXIT_CYC - 1);
   localparam logic [HOLD_W-1:0] INT_LAST = HOLD_W'(INT_HOLD_CYC - 1);
   localparam logic [MCD_W-1:0]  MCD_LAST = MCD_W'(MCD_CYC - 1);

   // ----------------------------------------
   // Register decode
   // ----------------------------------------

   // Software writes count only while the system runs out of reset.
   assign in_run   = (state == ST_RUN);
   assign wr_wdog  = in_run && reg_req.wr && reg_req.addr == WDOG_ADDR;
   assign wr_cause = in_run && reg_req.wr && reg_req.addr == CAUSE_ADDR;

   // ----------------------------------------
   // Watchdog control
   // ----------------------------------------

   // Run state, lock, interval and the two-write disable window.
   always_ff @(posedge clk_sys) begin
      if (srst || !in_run) begin
         watchdog_running <= 1'b1; // R9
         dis_lock         <= 1'b0; // R4
         interval         <= WD_IV_RST; // R8
         dis_arm          <= '0;
      end else if (wr_wdog) begin
         if (reg_req.wdata == CMD_ENABLE) begin
            watchdog_running <= 1'b1; // R1
         end
         if (reg_req.wdata == CMD_LOCK) begin
            dis_lock <= 1'b1; // R3
         end
         if (reg_req.wdata == CMD_DIS2 && dis_arm != '0 && !dis_lock) begin
            watchdog_running <= 1'b0; // R2 R4
         end
         // Any other write closes the window; a first-half write reopens it.
         dis_arm <= (reg_req.wdata == CMD_DIS1) ? DIS_WIN : 3'h0; // R2 R23
         if (!reg_req.wdata[WD_CMDBIT]) begin
            interval <= reg_req.wdata[2:0]; // R6
         end
      end else if (dis_arm != '0) begin
         dis_arm <= dis_arm - 3'h1; // R2
      end
   end

   // The enable command reloads the counter; the lock command does not.
   assign wd_restart = !in_run || (wr_wdog && reg_req.wdata == CMD_ENABLE); // R1 R3 R9

   rsc_wdog_timer #(
      .CNT_W (WDOG_CNT_W)
   ) u_wdog (
      .clk_sys  (clk_sys),
      .srst     (srst),
      .restart  (wd_restart),
      .run      (watchdog_running),
      .interval (interval),
      .expired  (wd_expired)
   );

   // ----------------------------------------
   // Reset-source enables
   // ----------------------------------------

   // Enable bits are write-only; every system reset returns them to default.
   always_ff @(posedge clk_sys) begin
      if (srst || !in_run) begin
         cnv_en  <= 1'b0;
         cmp_en  <= 1'b0;
         mcd_en  <= 1'b0;
         mon_sel <= 1'b1;
      end else if (wr_cause) begin
         cnv_en  <= reg_req.wdata[RC_CNV]; // R10
         cmp_en  <= reg_req.wdata[RC_CMP]; // R11
         mcd_en  <= reg_req.wdata[RC_MCD]; // R14
         mon_sel <= reg_req.wdata[RC_POR]; // R16
      end
   end

   // ----------------------------------------
   // Missing-clock detector
   // ----------------------------------------

   // Counts reference clocks since the last monitored tick.
   always_ff @(posedge clk_sys) begin
      if (srst || !mcd_en || monitored_clock_tick) begin
         mcd_cnt <= '0;
      end else if (mcd_cnt != MCD_LAST) begin
         mcd_cnt <= mcd_cnt + 1'b1;
      end
   end

   assign mcd_timeout = mcd_en && (mcd_cnt == MCD_LAST); // R15

   // ----------------------------------------
   // Reset cause selection
   // ----------------------------------------

   // One cause wins per reset, power-related causes first.
   always_comb begin
      next_trig  = 1'b1;
      next_por   = 1'b0;
      next_pin   = 1'b0;
      next_flags = CAUSE_NONE;
      if (!supply_above_threshold && supply_monitor_strap_pin && mon_sel) begin
         next_por   = 1'b1; // R16
         next_flags = CAUSE_POR; // R17
      end else if (wr_cause && reg_req.wdata[RC_PIN]) begin
         next_por   = 1'b1; // R19
         next_flags = CAUSE_POR; // R17
      end else if (!rst_pin_in && rst_pin_oe_n) begin
         next_pin       = 1'b1;
         next_flags.pin = 1'b1; // R20
      end else if (wr_cause && reg_req.wdata[RC_SW]) begin
         next_flags.sw = 1'b1; // R12
      end else if (wd_expired) begin
         next_flags.wdog = 1'b1; // R13
      end else if (mcd_timeout) begin
         next_flags.mcd = 1'b1; // R14
      end else if (cnv_en && !convert_start_input) begin
         next_flags.cnv = 1'b1; // R10
      end else if (cmp_en && !analog_comparator_zero) begin
         next_flags.cmp = 1'b1; // R11
      end else begin
         next_trig = 1'b0;
      end
   end

   // Flags change only on entry to reset, so they show the last cause alone.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cause_flags <= CAUSE_POR; // R17
      end else if (in_run && next_trig) begin
         cause_flags <= next_flags; // R22
      end
   end

   // ----------------------------------------
   // Reset sequencer
   // ----------------------------------------

   // Holds the system in reset and drives the pin for power-on kinds.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state        <= ST_HOLD;
         hold_cnt     <= POR_LAST;
         hold_por     <= 1'b1;
         sys_reset    <= 1'b1;
         rst_pin_oe_n <= 1'b0;
      end else begin
         unique case (state)
            ST_RUN: begin
               if (next_trig && next_pin) begin
                  state     <= ST_PIN_LOW;
                  hold_por  <= 1'b0;
                  sys_reset <= 1'b1;
               end else if (next_trig) begin
                  state        <= ST_HOLD;
                  hold_cnt     <= next_por ? POR_LAST : INT_LAST;
                  hold_por     <= next_por;
                  sys_reset    <= 1'b1;
                  rst_pin_oe_n <= !next_por; // R19 R12
               end
            end
            ST_PIN_LOW: begin
               // Leave reset a fixed time after the pin is released.
               if (rst_pin_in) begin
                  state    <= ST_HOLD;
                  hold_cnt <= PIN_LAST;
               end
            end
            ST_HOLD: begin
               if (hold_por && !supply_above_threshold) begin
                  hold_cnt <= POR_LAST; // R21
               end else if (hold_cnt == '0) begin
                  state        <= ST_RUN;
                  sys_reset    <= 1'b0;
                  rst_pin_oe_n <= 1'b1; // R21
               end else begin
                  hold_cnt <= hold_cnt - 1'b1; // R21
               end
            end
            default: begin
               state     <= ST_HOLD;
               hold_cnt  <= INT_LAST;
               sys_reset <= 1'b1;
            end
         endcase
      end
   end

   // The open-drain pin only ever pulls low.
   always_ff @(posedge clk_sys) begin
      rst_pin_out <= 1'b0;
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------

   // Read data stand in the cycle after the read strobe; others read zero.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         reg_rdata <= '0;
      end else if (reg_req.rd) begin
         unique case (reg_req.addr)
            WDOG_ADDR: begin
               reg_rdata             <= {5'h00, interval}; // R6
               reg_rdata[WD_RUNBIT]  <= watchdog_running; // R5
            end
            CAUSE_ADDR: begin
               reg_rdata <= {1'b0, cause_flags}; // R13 R17 R20 R22
            end
            default: begin
               reg_rdata <= '0;
            end
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

endmodule

`default_nettype wire

// ---- bench/rsc_reset_ctrl_checker.sv ----
// Assertion checker for the reset-source and watchdog block.
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_ctrl_checker
   import rsc_pkg::*;
(
   input wire logic         clk_sys,
   input wire logic         srst,
   input wire rsc_reg_req_t reg_req,
   input wire logic [7:0]   reg_rdata,
   input wire logic         rst_pin_in,
   input wire logic         rst_pin_out,
   input wire logic         rst_pin_oe_n,
   input wire logic         convert_start_input,
   input wire logic         analog_comparator_zero,
   input wire logic         supply_monitor_strap_pin,
   input wire logic         supply_above_threshold,
   input wire logic         monitored_clock_tick,
   input wire logic         sys_reset,
   input wire logic         watchdog_running
);
   // Register writes that the block accepts, one per register.
   wire wd_wr = reg_req.wr && reg_req.addr == WDOG_ADDR && !sys_reset;
   wire rc_wr = reg_req.wr && reg_req.addr == CAUSE_ADDR && !sys_reset;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   property p_run_read;
      $past(reg_req.rd) && $past(reg_req.addr) == WDOG_ADDR |->
         reg_rdata[4] == $past(watchdog_running) && reg_rdata[7:5] == 3'h0;
   endproperty
   a_run_read: assert property (p_run_read) else $error("status bit wrong");
   property p_enable;
      wd_wr && reg_req.wdata == CMD_ENABLE |=> watchdog_running;
   endproperty
   a_enable: assert property (p_enable) else $error("enable ignored");
   property p_lock;
      wd_wr && reg_req.wdata == CMD_LOCK && !watchdog_running |=> !watchdog_running;
   endproperty
   a_lock: assert property (p_lock) else $error("lock started watchdog");
   property p_dis_late;
      wd_wr && reg_req.wdata == CMD_DIS1 ##1 (!reg_req.wr && !sys_reset) [*4]
         ##1 (wd_wr && reg_req.wdata == CMD_DIS2) |=> watchdog_running == $past(watchdog_running);
   endproperty
   a_dis_late: assert property (p_dis_late) else $error("late disable taken");
   property p_rst_run;
      $fell(sys_reset) |-> watchdog_running;
   endproperty
   a_rst_run: assert property (p_rst_run) else $error("watchdog off after reset");
   property p_sw;
      rc_wr && reg_req.wdata == 8'h10 && supply_above_threshold && rst_pin_in
         |=> (sys_reset && rst_pin_oe_n) [*8];
   endproperty
   a_sw: assert property (p_sw) else $error("software reset wrong");
   property p_force_por;
      rc_wr && reg_req.wdata[0] |=> sys_reset && !rst_pin_oe_n;
   endproperty
   a_force_por: assert property (p_force_por) else $error("forced reset wrong");
   property p_pin_src;
      !rst_pin_in && rst_pin_oe_n && !sys_reset |=> sys_reset;
   endproperty
   a_pin_src: assert property (p_pin_src) else $error("pin reset missed");
   property p_oe;
      !rst_pin_oe_n |-> sys_reset && rst_pin_out == 1'h0;
   endproperty
   a_oe: assert property (p_oe) else $error("pin driven outside reset");
   property p_cnv;
      rc_wr && reg_req.wdata[6] ##1 (!sys_reset && !convert_start_input) |=> sys_reset;
   endproperty
   a_cnv: assert property (p_cnv) else $error("convert reset missed");
endmodule
bind rsc_reset_ctrl rsc_reset_ctrl_checker u_rsc_reset_ctrl_checker (
   .clk_sys(clk_sys), .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata),
   .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n),
   .convert_start_input(convert_start_input), .analog_comparator_zero(analog_comparator_zero),
   .supply_monitor_strap_pin(supply_monitor_strap_pin),
   .supply_above_threshold(supply_above_threshold), .monitored_clock_tick(monitored_clock_tick),
   .sys_reset(sys_reset), .watchdog_running(watchdog_running));
`default_nettype wire

// ---- bench/tb_rsc_reset_ctrl.sv ----
// Self-checking testbench of the reset-source and watchdog block.
`timescale 1ns/1ps
`default_nettype none
module tb_rsc_reset_ctrl;
   import rsc_pkg::*;
   localparam int unsigned POR_C = 20;
   localparam int unsigned MCD_C = 16;
   logic         clk_sys = 1'h0;
   logic         srst = 1'h1;
   rsc_reg_req_t req = '0;
   logic [7:0]   reg_rdata, d;
   logic         pin_drv = 1'h1, cnv = 1'h1, cmp = 1'h1, supply = 1'h1, tick = 1'h1;
   logic         rst_pin_out, rst_pin_oe_n, sys_reset, watchdog_running;
   wire          pin_lvl;
   integer       seed = 32'h55a609f6;
   int           n_mismatch = 0, n_checks = 0, n, i;
   logic [7:0]   en_t [0:6] = '{8'h40, 8'h20, 8'h04, 8'h02, 8'h10, 8'h01, 8'h00};
   logic [7:0]   exp_t [0:6] = '{8'h40, 8'h20, 8'h04, 8'h02, 8'h10, 8'h02, 8'h01};
   logic [6:0]   oe_t = 7'h57;
   // Clock of 10 ns period.
   always #5 clk_sys = ~clk_sys;
   // Open-drain reset wire: low when the block drives it, else the bench level.
   assign pin_lvl = rst_pin_oe_n ? pin_drv : rst_pin_out;
   rsc_reset_ctrl #(.POR_CYC(POR_C), .MCD_CYC(MCD_C)) u_rsc_reset_ctrl (
      .clk_sys(clk_sys), .srst(srst), .reg_req(req), .reg_rdata(reg_rdata),
      .rst_pin_in(pin_lvl), .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n),
      .convert_start_input(cnv), .analog_comparator_zero(cmp),
      .supply_monitor_strap_pin(1'h1), .supply_above_threshold(supply),
      .monitored_clock_tick(tick), .sys_reset(sys_reset), .watchdog_running(watchdog_running));
   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      req.addr <= a;
      req.wdata <= v;
      req.wr <= 1'h1;
      @(posedge clk_sys);
      req.wr <= 1'h0;
   endtask
   // Read data stand only in the cycle after the read strobe.
   // With the power-on flag set, the other cause flags carry no meaning.
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
      @(posedge clk_sys);
      req.addr <= a;
      req.rd <= 1'h1;
      @(posedge clk_sys);
      req.rd <= 1'h0;
      #1;
      chk(nm, e, (a == CAUSE_ADDR && e == 8'h02) ? (reg_rdata & 8'h02) : reg_rdata);
   endtask
   // Bounded wait for a reset level; n returns the cycles spent.
   task automatic wait_lvl(input logic v, input int lim);
      n = 0;
      #1;
      while (sys_reset !== v && n < lim) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (sys_reset !== v) begin
         chk("sys_reset", {7'h0, v}, {7'h0, sys_reset});
         finish_test;
      end
   endtask
   // Disable pair whose second write lands gap cycles after the first.
   task automatic dis(input int gap);
      wr(WDOG_ADDR, CMD_DIS1);
      repeat (gap - 2) @(posedge clk_sys);
      wr(WDOG_ADDR, CMD_DIS2);
   endtask
   task automatic idle_inputs;
      cnv <= 1'h1;
      cmp <= 1'h1;
      supply <= 1'h1;
      tick <= 1'h1;
      pin_drv <= 1'h1;
   endtask
   // Main sequence: power-on, watchdog commands, then every reset source.
   initial begin
      repeat (6) @(posedge clk_sys);
      srst <= 1'h0;
      #1;
      chk("pin drive at power-on", 8'h00, {7'h0, rst_pin_oe_n});
      wait_lvl(1'h0, 300);
      chk("power-on hold", 8'h01, {7'h0, n >= POR_C - 1 && n <= POR_C + 2});
      rd(CAUSE_ADDR, 8'h02, "cause after power-on");
      rd(WDOG_ADDR, 8'h17, "watchdog after reset");
      dis(4);
      rd(WDOG_ADDR, 8'h07, "stopped by disable");
      for (i = 0; i < 6; i++) begin
         d = 8'($random(seed)) & 8'h7f;
         wr(WDOG_ADDR, d);
         rd(WDOG_ADDR, d & 8'h07, "interval");
      end
      wr(WDOG_ADDR, 8'h07);
      wr(WDOG_ADDR, CMD_ENABLE);
      rd(WDOG_ADDR, 8'h17, "enabled");
      dis(5);
      rd(WDOG_ADDR, 8'h17, "late disable");
      wr(WDOG_ADDR, CMD_DIS1);
      wr(WDOG_ADDR, 8'h07);
      wr(WDOG_ADDR, CMD_DIS2);
      rd(WDOG_ADDR, 8'h17, "broken disable");
      dis(4);
      wr(WDOG_ADDR, CMD_LOCK);
      rd(WDOG_ADDR, 8'h07, "lock while stopped");
      wr(WDOG_ADDR, CMD_ENABLE);
      dis(4);
      rd(WDOG_ADDR, 8'h17, "locked disable");
      wr(WDOG_ADDR, CMD_ENABLE);
      wr(WDOG_ADDR, 8'h00);
      wait_lvl(1'h1, 200);
      chk("timeout length", 8'h01, {7'h0, n >= 61 && n <= 65});
      wait_lvl(1'h0, 100);
      rd(CAUSE_ADDR, 8'h08, "cause after timeout");
      rd(WDOG_ADDR, 8'h17, "watchdog after timeout");
      dis(4);
      rd(WDOG_ADDR, 8'h07, "lock cleared");
      wr(CAUSE_ADDR, 8'h00);
      cnv <= 1'h0;
      cmp <= 1'h0;
      supply <= 1'h0;
      tick <= 1'h0;
      n = 0;
      repeat (40) begin
         @(posedge clk_sys);
         #1;
         if (sys_reset !== 1'h0) n++;
      end
      chk("deselected sources", 8'h00, 8'(n));
      idle_inputs;
      for (i = 0; i < 7; i++) begin
         wr(CAUSE_ADDR, en_t[i]);
         case (i)
            0: cnv <= 1'h0;
            1: cmp <= 1'h0;
            2: tick <= 1'h0;
            3: supply <= 1'h0;
            6: pin_drv <= 1'h0;
            default: ;
         endcase
         wait_lvl(1'h1, 100);
         @(posedge clk_sys);
         #1;
         chk("pin drive", {7'h0, oe_t[i]}, {7'h0, rst_pin_oe_n});
         idle_inputs;
         wait_lvl(1'h0, 300);
         rd(CAUSE_ADDR, exp_t[i], "cause flags");
      end
      finish_test;
   end
endmodule
`default_nettype wire
